//--- design/pbmux_consts.svh
// constants for the port B address and clock pin multiplexer
`ifndef PBMUX_CONSTS_SVH
`define PBMUX_CONSTS_SVH

// word register offsets (byte addresses)
`define PBMUX_OFF_DATA_OUT 5'h00
`define PBMUX_OFF_DIRECTION 5'h04
`define PBMUX_OFF_PERIPH_EN 5'h08
`define PBMUX_OFF_PULLUP_EN 5'h0C
`define PBMUX_OFF_CLK_OUT_SEL 5'h10
`define PBMUX_OFF_BUS_CTRL 5'h14
`define PBMUX_OFF_PIN_IN 5'h18
`define PBMUX_OFF_STATUS 5'h1C

// field positions
`define PBMUX_BUS_DRIVE_HOLD_BIT 0
`define PBMUX_STAT_ADDR_DEFAULT_BIT 0
`define PBMUX_STAT_INIT_DONE_BIT 1
`define PBMUX_LOW_PIN_TOP 3
`define PBMUX_HIGH_PIN_BASE 4

// reset values
`define PBMUX_RST_DATA_OUT 8'h00
`define PBMUX_RST_DIRECTION 8'h00
`define PBMUX_RST_PERIPH_EN 8'hFF
`define PBMUX_RST_PULLUP_EN 8'hFF
`define PBMUX_RST_CLK_OUT_SEL 4'h0
`define PBMUX_RST_BUS_DRIVE_HOLD 1'b0
`define PBMUX_LOW_GPIO_ALL 4'hF
`define PBMUX_LOW_ADDR_ALL 4'h0

`endif

//--- design/pbmux_pkg.sv
// types shared by the port B pin multiplexer files
`default_nettype none
package pbmux_pkg;

  // start-up sequence, gray coded along the path
  typedef enum logic [1:0] {
    PBMUX_INIT_WAIT = 2'b00,
    PBMUX_INIT_LOAD = 2'b01,
    PBMUX_INIT_RUN = 2'b11
  } pbmux_init_t;

  typedef logic [7:0] pbmux_byte_t;

endpackage : pbmux_pkg
`default_nettype wire

//--- design/pbmux_strap_sel.sv
// captures the boot straps and derives the reset function of pins 0 to 3
`timescale 1ns/1ps
`default_nettype none
module pbmux_strap_sel
  import pbmux_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic capture_i,
  input wire logic boot_from_external_strap_i,
  input wire logic external_bus_mode_strap_i,
  input wire logic flash_secure_i,
  output logic addr_default_o
);
  // straps are caught one cycle after reset release, never by the reset itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_default_o <= 1'b0;
    end
    else if (capture_i)
    begin
      // a secured part only exposes the address bus when booting externally
      addr_default_o <= boot_from_external_strap_i |
                        (external_bus_mode_strap_i & ~flash_secure_i);
    end
  end
endmodule : pbmux_strap_sel
`default_nettype wire

//--- design/pbmux_pin_cell.sv
// one port B pin: function select, registered drive, pull-up
`timescale 1ns/1ps
`default_nettype none
module pbmux_pin_cell
  import pbmux_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gpio_en_i,
  input wire logic dir_out_i,
  input wire logic dout_i,
  input wire logic clk_sel_i,
  input wire logic addr_i,
  input wire logic clk_mon_i,
  input wire logic addr_drive_i,
  input wire logic pullup_en_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic pin_pullup_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else if (gpio_en_i)
    begin
      pin_out_o <= dout_i;
      pin_oe_o <= dir_out_i;
    end
    else if (clk_sel_i)
    begin
      pin_out_o <= clk_mon_i;
      pin_oe_o <= 1'b1;
    end
    else
    begin
      pin_out_o <= addr_i;
      pin_oe_o <= addr_drive_i;
    end
  end

  // pull-up stays on through reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_pullup_o <= 1'b1;
    end
    else
    begin
      pin_pullup_o <= pullup_en_i;
    end
  end
endmodule : pbmux_pin_cell
`default_nettype wire

//--- design/pbmux_top.sv
// port B address / clock monitor pin multiplexer with wishbone registers
// How it works
// - every pin selectable as GPIO input or output
// - pins 0-3 carry A16-A19, 4-7 carry A20-A23
// - idle bus tri-states address unless drive held
// - low pins reset function from straps and security
// - peripheral enable write overrides low pin function
// - pull-up off when its enable bit cleared
// - pins 4-7 show prescaler, system, system2, oscillator clocks
// - pins 4-7 reset to GPIO function
// - clearing enable bit hands only that pin over
// - clock select picks address or clock monitor
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pbmux_consts.svh"
module pbmux_top
  import pbmux_pkg::*;
#(
  parameter int PIN_COUNT = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // straps and security
  input wire logic boot_from_external_strap_i,
  input wire logic external_bus_mode_strap_i,
  input wire logic flash_secure_i,
  // external memory interface side
  input wire logic [7:0] ext_addr_hi_i,
  input wire logic ext_bus_active_i,
  input wire logic [3:0] ext_ctrl_i,
  output logic [3:0] ext_ctrl_o,
  output logic ext_ctrl_oe_o,
  // clocks offered for monitoring
  input wire logic prescaler_clock_i,
  input wire logic system_clock_out_i,
  input wire logic system_clock_second_i,
  input wire logic oscillator_clock_i,
  // port B pins
  input wire pbmux_pkg::pbmux_byte_t port_b_pins_in_i,
  output pbmux_pkg::pbmux_byte_t port_b_pins_out_o,
  output pbmux_pkg::pbmux_byte_t port_b_pins_oe_o,
  output pbmux_pkg::pbmux_byte_t port_b_pins_pullup_o
);
  import pbmux_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  pbmux_byte_t data_out_reg;
  pbmux_byte_t direction_reg;
  pbmux_byte_t port_b_peripheral_enable_reg;
  pbmux_byte_t port_b_pullup_enable_reg;
  logic [3:0] clock_output_select_reg;
  logic bus_drive_hold_reg;
  pbmux_byte_t pin_in_reg;
  pbmux_init_t init_reg;
  pbmux_init_t init_next;
  logic addr_default;
  logic bus_drive;
  logic wb_req;
  logic wr_en;
  logic [3:0] clk_mon;
  logic [7:0] clk_sel;
  logic [31:0] rd_next;
  logic [31:0] rd_word;

  // ****************************************
  // start-up sequence
  // ****************************************
  always_comb
  begin
    init_next = init_reg;
    case (init_reg)
      PBMUX_INIT_WAIT: init_next = PBMUX_INIT_LOAD;
      PBMUX_INIT_LOAD: init_next = PBMUX_INIT_RUN;
      PBMUX_INIT_RUN: init_next = PBMUX_INIT_RUN;
      default: init_next = PBMUX_INIT_WAIT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      init_reg <= PBMUX_INIT_WAIT;
    end
    else
    begin
      init_reg <= init_next;
    end
  end

  pbmux_strap_sel u_strap_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .capture_i(init_reg == PBMUX_INIT_WAIT),
    .boot_from_external_strap_i(boot_from_external_strap_i),
    .external_bus_mode_strap_i(external_bus_mode_strap_i),
    .flash_secure_i(flash_secure_i),
    .addr_default_o(addr_default)
  );

  // ****************************************
  // wishbone slave
  // ****************************************
  // one wait state: ack rises the edge after the request is seen
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (wb_adr_i)
      `PBMUX_OFF_DATA_OUT: rd_next[7:0] = data_out_reg;
      `PBMUX_OFF_DIRECTION: rd_next[7:0] = direction_reg;
      `PBMUX_OFF_PERIPH_EN: rd_next[7:0] = port_b_peripheral_enable_reg;
      `PBMUX_OFF_PULLUP_EN: rd_next[7:0] = port_b_pullup_enable_reg;
      `PBMUX_OFF_CLK_OUT_SEL: rd_next[3:0] = clock_output_select_reg;
      `PBMUX_OFF_BUS_CTRL: rd_next[`PBMUX_BUS_DRIVE_HOLD_BIT] = bus_drive_hold_reg;
      `PBMUX_OFF_PIN_IN: rd_next[7:0] = pin_in_reg;
      `PBMUX_OFF_STATUS:
      begin
        rd_next[`PBMUX_STAT_ADDR_DEFAULT_BIT] = addr_default;
        rd_next[`PBMUX_STAT_INIT_DONE_BIT] = (init_reg == PBMUX_INIT_RUN);
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // unmapped offsets answer with zero; read data is held between accesses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_word <= 32'h0000_0000;
    end
    else if (wb_req & ~wb_we_i)
    begin
      rd_word <= rd_next;
    end
  end

  assign wb_dat_o = rd_word;

  // ****************************************
  // software registers
  // ****************************************
  // data and direction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_out_reg <= `PBMUX_RST_DATA_OUT;
      direction_reg <= `PBMUX_RST_DIRECTION;
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_DATA_OUT)
    begin
      data_out_reg <= wb_dat_i[7:0];
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_DIRECTION)
    begin
      direction_reg <= wb_dat_i[7:0];
    end
  end

  // software write beats the strap default
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_b_peripheral_enable_reg <= `PBMUX_RST_PERIPH_EN;
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_PERIPH_EN)
    begin
      port_b_peripheral_enable_reg <= wb_dat_i[7:0];
    end
    else if (init_reg == PBMUX_INIT_LOAD)
    begin
      port_b_peripheral_enable_reg[`PBMUX_LOW_PIN_TOP:0] <=
        addr_default ? `PBMUX_LOW_ADDR_ALL : `PBMUX_LOW_GPIO_ALL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_b_pullup_enable_reg <= `PBMUX_RST_PULLUP_EN;
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_PULLUP_EN)
    begin
      port_b_pullup_enable_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_output_select_reg <= `PBMUX_RST_CLK_OUT_SEL;
      bus_drive_hold_reg <= `PBMUX_RST_BUS_DRIVE_HOLD;
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_CLK_OUT_SEL)
    begin
      clock_output_select_reg <= wb_dat_i[3:0];
    end
    else if (wr_en && wb_adr_i == `PBMUX_OFF_BUS_CTRL)
    begin
      bus_drive_hold_reg <= wb_dat_i[`PBMUX_BUS_DRIVE_HOLD_BIT];
    end
  end

  // input sampling, also in alternate modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_in_reg <= 8'h00;
    end
    else
    begin
      pin_in_reg <= port_b_pins_in_i;
    end
  end

  // ****************************************
  // pin multiplexing
  // ****************************************
  // address lines float while the bus idles, unless held
  assign bus_drive = bus_drive_hold_reg | ext_bus_active_i;

  // clock order on pins 4 to 7
  assign clk_mon = {oscillator_clock_i, system_clock_second_i,
                    system_clock_out_i, prescaler_clock_i};
  // only the high pins have a clock choice
  assign clk_sel = {clock_output_select_reg, 4'h0};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      // each pin steered by its own enable bit
      pbmux_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .gpio_en_i(port_b_peripheral_enable_reg[gi]),
        .dir_out_i(direction_reg[gi]),
        .dout_i(data_out_reg[gi]),
        .clk_sel_i(clk_sel[gi]),
        .addr_i(ext_addr_hi_i[gi]),
        .clk_mon_i((gi >= `PBMUX_HIGH_PIN_BASE) ? clk_mon[gi % 4] : 1'b0),
        .addr_drive_i(bus_drive),
        .pullup_en_i(port_b_pullup_enable_reg[gi]),
        .pin_out_o(port_b_pins_out_o[gi]),
        .pin_oe_o(port_b_pins_oe_o[gi]),
        .pin_pullup_o(port_b_pins_pullup_o[gi])
      );
    end
  endgenerate

  // control strobes share the idle tri-state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_ctrl_o <= 4'h0;
      ext_ctrl_oe_o <= 1'b0;
    end
    else
    begin
      ext_ctrl_o <= ext_ctrl_i;
      ext_ctrl_oe_o <= bus_drive;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // output driver
  gpio_out_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    port_b_peripheral_enable_reg[0] && direction_reg[0]
    |=> port_b_pins_oe_o[0] && port_b_pins_out_o[0] == $past(data_out_reg[0]))
    else $error("gpio output pin not driven with data");

  gpio_input_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_b_peripheral_enable_reg & ~direction_reg) != 8'h00
    |=> ((port_b_pins_oe_o & $past(port_b_peripheral_enable_reg & ~direction_reg)) == 8'h00))
    else $error("gpio input pin is driving");

  addr_line_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_b_peripheral_enable_reg[5] && !clock_output_select_reg[1]
    |=> port_b_pins_out_o[5] == $past(ext_addr_hi_i[5]))
    else $error("pin 5 does not carry address line 21");

  addr_idle_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_b_peripheral_enable_reg[0] && !bus_drive_hold_reg && !ext_bus_active_i
    |=> !port_b_pins_oe_o[0] && !ext_ctrl_oe_o)
    else $error("address pin driven while bus idle");

  strap_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(init_reg == PBMUX_INIT_WAIT) && init_reg == PBMUX_INIT_LOAD
    && !(wr_en && wb_adr_i == `PBMUX_OFF_PERIPH_EN)
    |=> port_b_peripheral_enable_reg[3:0] ==
        (($past(boot_from_external_strap_i, 2) |
          ($past(external_bus_mode_strap_i, 2) & ~$past(flash_secure_i, 2)))
         ? 4'h0 : 4'hF))
    else $error("low pins not loaded from straps");

  periph_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == `PBMUX_OFF_PERIPH_EN
    |=> port_b_peripheral_enable_reg == $past(wb_dat_i[7:0]))
    else $error("peripheral enable write lost");

  pullup_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> port_b_pins_pullup_o == $past(port_b_pullup_enable_reg))
    else $error("pull-up does not follow its enable");

  clk_monitor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_b_peripheral_enable_reg[7] && clock_output_select_reg[3]
    |=> port_b_pins_oe_o[7] && port_b_pins_out_o[7] == $past(oscillator_clock_i))
    else $error("pin 7 not showing oscillator clock");

  high_gpio_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> port_b_peripheral_enable_reg[7:4] == 4'hF)
    else $error("high pins not gpio after reset");

  clk_sel_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_b_peripheral_enable_reg[4] && !clock_output_select_reg[0]
    |=> port_b_pins_out_o[4] == $past(ext_addr_hi_i[4])
        && port_b_pins_oe_o[4] == $past(bus_drive))
    else $error("pin 4 not on address with clock select off");

  // wishbone ack is a single cycle
  wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : pbmux_top
`default_nettype wire

//--- verif/pbmux_ext_mem.sv
// far-side model: external memory side and board wiring of the port B pins
`timescale 1ns/1ps
`default_nettype none
module pbmux_ext_mem
  import pbmux_pkg::*;
(
  input wire logic clk_i,
  input wire pbmux_pkg::pbmux_byte_t pin_out_i,
  input wire pbmux_pkg::pbmux_byte_t pin_oe_i,
  input wire pbmux_pkg::pbmux_byte_t pin_pullup_i,
  input wire pbmux_pkg::pbmux_byte_t drv_en_i,
  input wire pbmux_pkg::pbmux_byte_t drv_val_i,
  output pbmux_pkg::pbmux_byte_t pin_level_o
);
  import pbmux_pkg::*;
  pbmux_byte_t float_reg = 8'h55;

  // an undriven pin without pull-up must not look stable, so it flips every cycle
  always_ff @(posedge clk_i)
  begin
    float_reg <= ~float_reg;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe_i[i])
        pin_level_o[i] = pin_out_i[i];
      else if (drv_en_i[i])
        pin_level_o[i] = drv_val_i[i];
      else
        pin_level_o[i] = pin_pullup_i[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule : pbmux_ext_mem
`default_nettype wire

//--- verif/pbmux_top_tb.sv
// self-checking bench for the port B pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pbmux_consts.svh"
module pbmux_top_tb;
  import pbmux_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic boot_i = 1'b0;
  logic mode_i = 1'b0;
  logic sec_i = 1'b0;
  logic act = 1'b0;
  logic ctrl_oe;
  logic [3:0] ctrl_in = 4'h0;
  logic [3:0] ctrl_out;
  logic [3:0] clks = 4'h0;
  pbmux_byte_t addr_hi = 8'h00;
  pbmux_byte_t drv_en = 8'h00;
  pbmux_byte_t drv_val = 8'h00;
  pbmux_byte_t pin_lvl, pin_out, pin_oe, pin_pu;
  int error_cnt = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  pbmux_top #(.PIN_COUNT(8)) pbmux_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .boot_from_external_strap_i(boot_i),
    .external_bus_mode_strap_i(mode_i), .flash_secure_i(sec_i), .ext_addr_hi_i(addr_hi),
    .ext_bus_active_i(act), .ext_ctrl_i(ctrl_in), .ext_ctrl_o(ctrl_out),
    .ext_ctrl_oe_o(ctrl_oe), .prescaler_clock_i(clks[0]), .system_clock_out_i(clks[1]),
    .system_clock_second_i(clks[2]), .oscillator_clock_i(clks[3]),
    .port_b_pins_in_i(pin_lvl), .port_b_pins_out_o(pin_out), .port_b_pins_oe_o(pin_oe),
    .port_b_pins_pullup_o(pin_pu));

  pbmux_ext_mem pbmux_ext_mem_i (
    .clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_pullup_i(pin_pu),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .pin_level_o(pin_lvl));

  // ****************************************
  // checking and bus helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [4:0] adr, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] %0t bus cycle never acknowledged", $time);
      tally_and_finish();
    end
  endtask : wb

  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, adr, 8'h00, q);
    check(q, exp, what);
  endtask : rd

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : do_reset

  // pin function per pin: gpio, clock monitor or address line; returns {out, oe}
  function automatic logic [15:0] exp_pins(pbmux_byte_t per, pbmux_byte_t dir,
      pbmux_byte_t dat, logic [3:0] cs, pbmux_byte_t adr, logic [3:0] ck, logic drv);
    pbmux_byte_t o, e;
    for (int i = 0; i < 8; i++)
    begin
      o[i] = per[i] ? dat[i] : (i > 3 && cs[i-4]) ? ck[i-4] : adr[i];
      e[i] = per[i] ? dir[i] : (i > 3 && cs[i-4]) ? 1'b1 : drv;
    end
    return {o, e};
  endfunction : exp_pins

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] q;
    pbmux_byte_t per, dir, dat, pu, lv, m;
    logic [3:0] cs;
    logic hold, ad;
    logic [15:0] e;
    void'($urandom(32'h84F1));
    for (int k = 0; k < 8; k++)
    begin
      {boot_i, mode_i, sec_i} <= k[2:0];
      act <= 1'b1;
      do_reset();
      ad = k[2] | (k[1] & ~k[0]);
      rd(`PBMUX_OFF_STATUS, {30'h0, 1'b1, ad}, "status after reset");
      rd(`PBMUX_OFF_PERIPH_EN, ad ? 32'hF0 : 32'hFF, "enable after reset");
      check(32'(pin_oe), ad ? 32'h0F : 32'h00, "drive after reset");
    end
    rd(`PBMUX_OFF_DATA_OUT, 32'h0, "data reset");
    rd(`PBMUX_OFF_DIRECTION, 32'h0, "direction reset");
    rd(`PBMUX_OFF_PULLUP_EN, 32'hFF, "pull-up reset");
    rd(`PBMUX_OFF_CLK_OUT_SEL, 32'h0, "clock select reset");
    rd(`PBMUX_OFF_BUS_CTRL, 32'h0, "bus control reset");
    wr(`PBMUX_OFF_STATUS, 8'h00);
    rd(`PBMUX_OFF_STATUS, 32'h3, "status is read-only");
    // a write with byte lane 0 off is acked but must leave the register alone
    wr(`PBMUX_OFF_DATA_OUT, 8'hA5);
    wb_sel_i <= 4'h0;
    wr(`PBMUX_OFF_DATA_OUT, 8'h5A);
    wb_sel_i <= 4'hF;
    rd(`PBMUX_OFF_DATA_OUT, 32'hA5, "write with lane 0 off");
    rd(5'h02, 32'h0, "unmapped offset");
    // first eight passes hand over exactly one pin each, the rest are random
    for (int n = 0; n < 48; n++)
    begin
      per = (n < 8) ? ~(8'h01 << n) : 8'($urandom);
      dir = 8'($urandom);
      dat = 8'($urandom);
      pu = 8'($urandom);
      cs = 4'($urandom);
      hold = 1'($urandom);
      @(posedge clk_i);
      addr_hi <= 8'($urandom);
      clks <= 4'($urandom);
      act <= 1'($urandom);
      ctrl_in <= 4'($urandom);
      drv_en <= 8'($urandom);
      drv_val <= 8'($urandom);
      wr(`PBMUX_OFF_DATA_OUT, dat);
      wr(`PBMUX_OFF_DIRECTION, dir);
      wr(`PBMUX_OFF_PERIPH_EN, per);
      wr(`PBMUX_OFF_PULLUP_EN, pu);
      wr(`PBMUX_OFF_CLK_OUT_SEL, {4'h0, cs});
      wr(`PBMUX_OFF_BUS_CTRL, {7'h0, hold});
      repeat (2) @(posedge clk_i);
      #1;
      e = exp_pins(per, dir, dat, cs, addr_hi, clks, hold | act);
      check(32'(pin_out), 32'(e[15:8]), "pin output");
      check(32'(pin_oe), 32'(e[7:0]), "pin drive");
      check(32'(pin_pu), 32'(pu), "pull-up");
      check({27'h0, ctrl_oe, ctrl_out}, {27'h0, hold | act, ctrl_in}, "bus control");
      lv = (e[7:0] & e[15:8]) | (~e[7:0] & drv_en & drv_val) | (~e[7:0] & ~drv_en);
      m = e[7:0] | drv_en | pu;
      wb(1'b0, `PBMUX_OFF_PIN_IN, 8'h00, q);
      check(32'(q[7:0] & m), 32'(lv & m), "pin input");
    end
    tally_and_finish();
  end
endmodule : pbmux_top_tb
`default_nettype wire
